// ---- pkg/gdf_pkg.sv ----
// Constants for the gate input deglitch filter
//----------------------------------------------------------------------
// Function
// - Same filter on every high and low input
// - Pulses shorter than filter time vanish entirely
// - Low input ignores short positive spikes
// - High input ignores short negative spikes
// - Accepted pulse keeps its input width
// - Long negative return transient holds high side off
// - Outputs in phase; both high forces both low
//----------------------------------------------------------------------
package gdf_pkg;
  // Clock period in picoseconds
  localparam int CLK_PERIOD_PS = 4000;
  // Filter time in nanoseconds
  localparam int FILTER_TIME_NS = 200;
  // Filter time in cycles, rounded up, no lower bound
  localparam int FILTER_CYCLES =
    (FILTER_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Least transient duration in nanoseconds
  localparam int TRANSIENT_TIME_NS = 50;
  // Transient duration in cycles, rounded up
  localparam int TRANSIENT_CYCLES =
    (TRANSIENT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // High-side hold time in nanoseconds
  localparam int HOLD_TIME_NS = 4500;
  // Hold time in cycles, rounded down
  localparam int HOLD_CYCLES = (HOLD_TIME_NS * 1000) / CLK_PERIOD_PS;
  // Number of phases
  localparam int PHASES = 3;
  // Counter width
  localparam int CNT_W = 12;
endpackage

// ---- hdl/gdf_channel.sv ----
// One symmetric deglitch filter channel
`timescale 1ns/1ps
module gdf_channel #(
  parameter int CYCLES = gdf_pkg::FILTER_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // Synchronised input and filtered output
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic cand;
    logic [gdf_pkg::CNT_W-1:0] cnt;
    logic out;
  } gdf_chan_t;

  gdf_chan_t s_q, s_d;

  //--------------------------------------------------------------------
  // Stability counter
  //--------------------------------------------------------------------
  // A level must stay stable for CYCLES + 1 cycles to be accepted; the same
  // latency on both edges keeps output width equal to input width
  always_comb begin
    s_d = s_q;
    if (din != s_q.cand) begin
      s_d.cand = din;
      s_d.cnt = '0;
    end else if (s_q.cnt < gdf_pkg::CNT_W'(CYCLES - 1)) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end else begin
      s_d.out = s_q.cand;
    end
  end

  // State register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.out;
endmodule

// ---- hdl/gdf_top.sv ----
// Three-phase gate input deglitch filter with high-side hold-off
`timescale 1ns/1ps
module gdf_top #(
  parameter int PHASES = gdf_pkg::PHASES,
  parameter int FILTER_CYCLES = gdf_pkg::FILTER_CYCLES,
  parameter int TRANSIENT_CYCLES = gdf_pkg::TRANSIENT_CYCLES,
  parameter int HOLD_CYCLES = gdf_pkg::HOLD_CYCLES
) (
  // Clock, reset, enable
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CLK_EN,
  // Logic inputs from host
  input wire logic [PHASES-1:0] HIGH_SIDE_INPUT,
  input wire logic [PHASES-1:0] LOW_SIDE_INPUT,
  // Comparator flag: switch node return below negative limit
  input wire logic [PHASES-1:0] SWITCH_NODE_RETURN_NEG,
  // Gate outputs
  output logic [PHASES-1:0] HIGH_SIDE_GATE_OUT,
  output logic [PHASES-1:0] LOW_SIDE_GATE_OUT,
  // High-side hold-off active
  output logic HOLD_OFF_ACTIVE
);
  localparam int W = 2 * PHASES;

  typedef struct packed {
    logic [W-1:0] sync1;
    logic [W-1:0] sync2;
    logic [PHASES-1:0] neg1;
    logic [PHASES-1:0] neg2;
    logic [gdf_pkg::CNT_W-1:0] neg_cnt;
    logic [gdf_pkg::CNT_W-1:0] hold_cnt;
    logic hold;
    logic [PHASES-1:0] hs_out;
    logic [PHASES-1:0] ls_out;
  } gdf_top_t;

  gdf_top_t s_q, s_d;
  logic [W-1:0] filt;

  //--------------------------------------------------------------------
  // Per-input filters
  //--------------------------------------------------------------------
  // Identical filter on every input
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_ch
      gdf_channel #(.CYCLES(FILTER_CYCLES)) u_ch (
        .clk(CLK),
        .reset(RESET),
        .clk_en(CLK_EN),
        .din(s_q.sync2[i]),
        .dout(filt[i])
      );
    end
  endgenerate

  //--------------------------------------------------------------------
  // Transient hold-off and output logic
  //--------------------------------------------------------------------
  // Sync pins, time negative transient, apply truth table
  always_comb begin
    s_d = s_q;
    s_d.sync1 = {LOW_SIDE_INPUT, HIGH_SIDE_INPUT};
    s_d.sync2 = s_q.sync1;
    s_d.neg1 = SWITCH_NODE_RETURN_NEG;
    s_d.neg2 = s_q.neg1;
    // Any phase below limit counts toward transient duration
    if (|s_q.neg2) begin
      if (s_q.neg_cnt < gdf_pkg::CNT_W'(TRANSIENT_CYCLES)) begin
        s_d.neg_cnt = s_q.neg_cnt + 1'b1;
      end
    end else begin
      s_d.neg_cnt = '0;
    end
    // Lasting at least the limit starts or restarts the hold
    if (s_q.neg_cnt >= gdf_pkg::CNT_W'(TRANSIENT_CYCLES)) begin
      s_d.hold = 1'b1;
      s_d.hold_cnt = gdf_pkg::CNT_W'(HOLD_CYCLES - 1);
    end else if (s_q.hold) begin
      if (s_q.hold_cnt == '0) begin
        s_d.hold = 1'b0;
      end else begin
        s_d.hold_cnt = s_q.hold_cnt - 1'b1;
      end
    end
    // Non-inverting, both high forces both low
    for (int p = 0; p < PHASES; p++) begin
      s_d.hs_out[p] = filt[p] & ~filt[PHASES+p] & ~s_d.hold;
      s_d.ls_out[p] = filt[PHASES+p] & ~filt[p];
    end
  end

  // State register
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      s_q <= '0;
    end else if (CLK_EN) begin
      s_q <= s_d;
    end
  end

  assign HIGH_SIDE_GATE_OUT = s_q.hs_out;
  assign LOW_SIDE_GATE_OUT = s_q.ls_out;
  assign HOLD_OFF_ACTIVE = s_q.hold;
endmodule

// ---- testbench/gdf_host.sv ----
// Host model driving the gate inputs
`timescale 1ns/1ps
module gdf_host (
  // Clock and commands
  input wire logic clk,
  input wire logic [2:0] hs_cmd, ls_cmd, neg_cmd,
  // Pins into the filter
  output logic [2:0] hs = 3'h0, ls = 3'h0, neg = 3'h0
);
  // Launch commands one edge later, like a port register
  always @(posedge clk) begin
    hs <= hs_cmd;
    ls <= ls_cmd;
    neg <= neg_cmd;
  end
endmodule

// ---- testbench/gdf_chk_properties.sv ----
// Port assertions for the deglitch filter
`timescale 1ns/1ps
module gdf_chk #(parameter int F = 4, H = 20) (
  input wire logic CLK, RESET, CLK_EN,
  input wire logic [2:0] HIGH_SIDE_INPUT, LOW_SIDE_INPUT,
  input wire logic [2:0] SWITCH_NODE_RETURN_NEG,
  input wire logic [2:0] HIGH_SIDE_GATE_OUT, LOW_SIDE_GATE_OUT,
  input wire logic HOLD_OFF_ACTIVE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  wire [2:0] hi = HIGH_SIDE_INPUT, li = LOW_SIDE_INPUT;
  wire [2:0] ho = HIGH_SIDE_GATE_OUT, lo = LOW_SIDE_GATE_OUT;
  wire ng = |SWITCH_NODE_RETURN_NEG, hd = HOLD_OFF_ACTIVE;
  property p_excl; (ho & lo) == 3'h0; endproperty
  a_excl: assert property (p_excl) else $error("both on");
  property p_forced; hd |-> ho == 3'h0; endproperty
  a_forced: assert property (p_forced) else $error("high in hold");
  property p_hrise; $rose(ho[0]) |-> $past(hi[0], 5) && $past(hi[0], F+2);
  endproperty
  a_hrise: assert property (p_hrise) else $error("early rise");
  property p_lrise; $rose(lo[2]) |-> $past(li[2], 5) && $past(li[2], F+2);
  endproperty
  a_lrise: assert property (p_lrise) else $error("early low");
  property p_trig; ng [*8] |=> hd; endproperty
  a_trig: assert property (p_trig) else $error("no hold");
  property p_src; $rose(hd) |-> $past(ng, 5); endproperty
  a_src: assert property (p_src) else $error("hold no cause");
  property p_min; $rose(hd) |=> hd [*8]; endproperty
  a_min: assert property (p_min) else $error("hold short");
  property p_len; $fell(hd) |-> !$past(ng, H); endproperty
  a_len: assert property (p_len) else $error("hold early end");
endmodule
bind gdf_top gdf_chk #(.F(FILTER_CYCLES), .H(HOLD_CYCLES)) gdf_chk_i (.*);

// ---- testbench/test_gdf_top.sv ----
// Testbench for the deglitch filter
`timescale 1ns/1ps
module test_gdf_top;
  logic clk = 0, rst = 1, en = 1;
  logic [2:0] hc = 0, lc = 0, nc = 0, hs, ls, ng, ho, lo;
  logic hold;
  int fails = 0, check_count = 0, nh, nl;
  // Clock
  always #2 clk = ~clk;
  gdf_host gdf_host_i (.clk(clk), .hs_cmd(hc), .ls_cmd(lc),
    .neg_cmd(nc), .hs(hs), .ls(ls), .neg(ng));
  gdf_top #(.FILTER_CYCLES(4), .TRANSIENT_CYCLES(3), .HOLD_CYCLES(20))
    gdf_top_i (.CLK(clk), .RESET(rst), .CLK_EN(en),
    .HIGH_SIDE_INPUT(hs), .LOW_SIDE_INPUT(ls),
    .SWITCH_NODE_RETURN_NEG(ng), .HIGH_SIDE_GATE_OUT(ho),
    .LOW_SIDE_GATE_OUT(lo), .HOLD_OFF_ACTIVE(hold));
  task automatic conclude;
    $display("fails=%0d checks=%0d", fails, check_count);
    if (fails == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input bit ok, input string m);
    check_count++;
    if (!ok) begin
      fails++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic put(input int p, input bit h, l, n);
    @(posedge clk);
    hc[p] <= h;
    lc[p] <= l;
    nc[p] <= n;
  endtask
  // Count high output cycles of one phase
  task automatic run(input int p, n);
    repeat (n) begin
      @(negedge clk);
      nh += (ho[p] === 1'b1);
      nl += (lo[p] === 1'b1);
    end
  endtask
  task automatic pulse(input int p, w, input bit low);
    nh = 0;
    nl = 0;
    put(p, !low, low, 0);
    run(p, w);
    put(p, 0, 0, 0);
    run(p, 20);
    if (low)
      nh = nl;
    chk(w < 4 ? nh == 0 : nh >= w - 1 && nh <= w + 1, "pulse width");
  endtask
  task automatic t_hold;
    put(0, 1, 0, 0);
    run(0, 12);
    put(2, 0, 0, 1);
    run(0, 10);
    chk(hold === 1'b1 && ho[0] === 1'b0, "hold on");
    put(2, 0, 0, 0);
    run(0, 17);
    chk(hold === 1'b1, "hold length");
    run(0, 10);
    chk(hold === 1'b0 && ho[0] === 1'b1, "hold end");
    nh = 0;
    put(2, 0, 0, 1);
    run(0, 2);
    put(2, 0, 0, 0);
    run(0, 10);
    chk(nh == 12, "short transient");
    nh = 0;
    put(0, 0, 1, 0);
    run(0, 3);
    put(0, 1, 0, 0);
    run(0, 12);
    chk(nh == 15, "low notch");
    put(0, 1, 1, 0);
    run(0, 12);
    chk(ho[0] === 1'b0 && lo[0] === 1'b0, "both high");
  endtask
  // Enable low freezes the filter, release resumes it
  task automatic t_freeze;
    nh = 0;
    @(posedge clk);
    en <= 1'b0;
    put(1, 1, 0, 0);
    run(1, 30);
    chk(nh == 0, "freeze");
    @(posedge clk);
    en <= 1'b1;
    run(1, 12);
    chk(ho[1] === 1'b1, "thaw");
    put(1, 0, 0, 0);
    run(1, 12);
  endtask
  // Watchdog
  initial begin
    #12000;
    fails++;
    conclude();
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    for (int p = 0; p < 3; p++) begin
      pulse(p, 3, 0);
      pulse(p, 3, 1);
      pulse(p, 9, 0);
      pulse(p, 5, 1);
    end
    t_freeze();
    t_hold();
    conclude();
  end
endmodule
